// ---- rtl/emc_mac_core.sv ----
// Receive classifier, MDIO shifter, MII/RMII adapter and descriptor rings
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module emc_mac_core #(
  parameter int RX_MAX_STD = 1518,
  parameter int RX_MAX_BIG = 1536
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       mdc,
  input  wire logic                  mdio_i,
  output logic                       mdio_o,
  output logic                       mdio_oe,
  output logic                       mgmt_done_pulse,
  input  wire emc_pkg::emc_rx_pins_t rx_pins,
  input  wire logic                  tx_or_ref_clock,
  output emc_pkg::emc_tx_pins_t      tx_pins,
  input  wire emc_pkg::emc_tx_src_t  tx_src,
  output logic                       tx_take,
  output emc_pkg::emc_rx_stat_t      rx_stat,
  input  wire logic [31:0]           rx_desc_w0,
  input  wire logic                  rx_desc_next,
  output logic [31:0]                rx_desc_ptr,
  output logic                       rx_desc_ours,
  input  wire logic [31:0]           tx_desc_w1,
  input  wire logic                  tx_desc_next,
  output logic [31:0]                tx_desc_ptr,
  output logic                       tx_desc_ours,
  output logic                       tx_desc_err
);
  import emc_pkg::*;

  // Byte counter is 14 bits wide
  if (RX_MAX_BIG < RX_MAX_STD || RX_MAX_BIG > 16383) begin : g_bad_max
    $error("RX_MAX_BIG must be in RX_MAX_STD..16383");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    M_IDLE  = 3'b001,
    M_PRE   = 3'b010,
    M_SHIFT = 3'b100
  } emc_mst_t;

  typedef enum logic [2:0] {
    R_IDLE = 3'b001,
    R_PRE  = 3'b010,
    R_DATA = 3'b100
  } emc_rst_t;

  typedef struct packed {
    logic [31:0]  rdata;
    logic [31:0]  ncr;
    logic [31:0]  ncfg;
    logic [31:0]  man;
    logic [15:0]  tid;
    logic         rmii;
    logic [31:0]  rbase;
    logic [31:0]  rcur;
    logic [31:0]  tbase;
    logic [31:0]  tcur;
    logic [7:0]   tbufs;
    logic         terr;
    emc_mst_t     ms;
    logic [6:0]   mcnt;
    logic [5:0]   mbit;
    logic         mrd;
    logic         mdc;
    logic         mdo;
    logic         moe;
    logic         midle;
    logic         mirq;
    logic         rck;
    logic         tck;
    emc_rst_t     rs;
    logic         rhalf;
    logic [1:0]   rlo;
    logic         bhalf;
    logic [3:0]   lonib;
    logic [13:0]  rcnt;
    logic [15:0]  rtype;
    logic [15:0]  rtci;
    emc_rx_stat_t stat;
    logic         tphase;
    logic [1:0]   thi;
    emc_tx_pins_t tx;
    logic         take;
  } emc_state_t;

  emc_state_t s_q;
  emc_state_t s_d;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic hit;
  logic wr;
  logic [31:0] rd_mux;
  logic [6:0] div;
  logic [6:0] half;

  always_comb begin
    case (paddr)
      OFF_NCR, OFF_NCFG, OFF_NSR, OFF_RBQP,
      OFF_TBQP, OFF_MAN, OFF_TID, OFF_USRIO: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  assign wr = psel & penable & pwrite & hit;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_NCR:   rd_mux = s_q.ncr;
      OFF_NCFG:  rd_mux = s_q.ncfg;
      OFF_NSR: begin
        rd_mux[NSR_IDLE] = s_q.midle;
        rd_mux[NSR_MDIO] = mdio_i;
      end
      OFF_RBQP:  rd_mux = s_q.rcur;
      OFF_TBQP:  rd_mux = s_q.tcur;
      OFF_MAN:   rd_mux = s_q.man;
      OFF_TID:   rd_mux[15:0] = s_q.tid;
      OFF_USRIO: rd_mux[0] = s_q.rmii;
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  // Clock select 0..3 gives divide 8, 16, 32, 64
  assign div  = MDC_BASE << s_q.ncfg[CFG_CLK +: 2];
  assign half = div >> 1;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic       redge;
  logic       tedge;
  logic       nv;
  logic [3:0] nib;
  logic       rdv;
  logic [7:0] byt;
  logic       bv;
  logic [13:0] rmax;

  always_comb begin
    s_d  = s_q;
    nv   = 1'b0;
    nib  = rx_pins.rxd;
    bv   = 1'b0;
    byt  = {rx_pins.rxd, s_q.lonib};
    // Reduced mode runs both paths from the reference clock
    redge = s_q.rmii ? (tx_or_ref_clock & ~s_q.tck)
                     : (rx_pins.clk & ~s_q.rck);
    tedge = tx_or_ref_clock & ~s_q.tck;
    rdv   = rx_pins.dv;
    rmax  = s_q.ncfg[CFG_BIG] ? 14'(RX_MAX_BIG)
                              : 14'(RX_MAX_STD);
    s_d.rck  = rx_pins.clk;
    s_d.tck  = tx_or_ref_clock;
    s_d.mirq = 1'b0;
    s_d.take = 1'b0;
    s_d.stat.valid = 1'b0;
    if (psel & ~penable) begin
      s_d.rdata = rd_mux;
    end

    if (wr) begin
      case (paddr)
        OFF_NCR:   s_d.ncr = pwdata;
        OFF_NCFG:  s_d.ncfg = pwdata;
        OFF_TID:   s_d.tid = pwdata[15:0];
        OFF_USRIO: s_d.rmii = pwdata[0];
        OFF_RBQP: begin
          s_d.rbase = pwdata;
          s_d.rcur  = pwdata;
        end
        OFF_TBQP: begin
          s_d.tbase = pwdata;
          s_d.tcur  = pwdata;
          s_d.tbufs = 8'h00;
        end
        OFF_MAN: begin
          // Writes while busy are dropped
          if (s_q.ms == M_IDLE) begin
            s_d.man   = pwdata;
            s_d.mrd   = pwdata[29:28] == OP_READ;
            s_d.ms    = M_PRE;
            s_d.mcnt  = 7'h00;
            s_d.mbit  = 6'h00;
            s_d.midle = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // MDIO: 32 preamble ones then the 32-bit frame
    case (s_q.ms)
      M_IDLE: ;
      M_PRE, M_SHIFT: begin
        s_d.mcnt = s_q.mcnt + 7'h01;
        if (s_q.mcnt == half - 7'h01) begin
          s_d.mdc = 1'b1;
          if (s_q.ms == M_SHIFT) begin
            // Own bits rotate back home; released bits take the PHY
            s_d.man = {s_q.man[30:0],
                       s_q.moe ? s_q.man[31] : mdio_i};
          end
        end
        if (s_q.mcnt == div - 7'h01) begin
          s_d.mdc  = 1'b0;
          s_d.mcnt = 7'h00;
          s_d.mbit = s_q.mbit + 6'h01;
          if (s_q.ms == M_PRE && s_q.mbit == MDIO_PRE) begin
            s_d.ms   = M_SHIFT;
            s_d.mbit = 6'h00;
          end else if (s_q.ms == M_SHIFT
                       && s_q.mbit == MDIO_LAST) begin
            s_d.ms    = M_IDLE;
            s_d.midle = 1'b1;
            s_d.mirq  = 1'b1;
          end
        end
      end
      default: s_d.ms = M_IDLE;
    endcase
    s_d.mdo = (s_d.ms == M_SHIFT) ? s_d.man[31] : 1'b1;
    s_d.moe = (s_d.ms == M_PRE)
            | (s_d.ms == M_SHIFT
               & ~(s_d.mrd & s_d.mbit >= MDIO_TA));

    // Receive: nibble or dibit pairing, then bytes
    if (redge) begin
      case (s_q.rs)
        R_IDLE: begin
          if (rdv & s_q.ncr[NCR_RE]) begin
            s_d.rs = R_PRE;
          end
        end
        R_PRE: begin
          if (!rdv) begin
            s_d.rs = R_IDLE;
          end else if (s_q.rmii ? rx_pins.rxd[1:0] == SFD_DIBIT
                                : rx_pins.rxd == SFD_NIB) begin
            s_d.rs    = R_DATA;
            s_d.rhalf = 1'b0;
            s_d.bhalf = 1'b0;
            s_d.rcnt  = 14'h0000;
            s_d.rtype = 16'h0000;
            s_d.rtci  = 16'h0000;
          end
        end
        R_DATA: begin
          if (!rdv) begin
            s_d.rs = R_IDLE;
            s_d.stat.valid    = 1'b1;
            s_d.stat.too_long = s_q.rcnt > rmax;
            s_d.stat.word     = 32'h0000_0000;
            s_d.stat.word[10:0] = s_q.rcnt[10:0];
            if (s_q.rcnt >= 14'd14) begin
              s_d.stat.word[ST_TID] =
                s_q.rtype == s_q.tid;
            end
            if (s_q.rtype == TPID_VLAN) begin
              s_d.stat.word[ST_VLAN] = 1'b1;
              s_d.stat.word[ST_PRI] =
                s_q.rtci[11:0] == 12'h000;
              s_d.stat.word[ST_PRIO +: 3] =
                s_q.rtci[15:13];
              s_d.stat.word[ST_CFI] = s_q.rtci[12];
            end
          end else if (s_q.rmii) begin
            s_d.rhalf = ~s_q.rhalf;
            s_d.rlo   = rx_pins.rxd[1:0];
            if (s_q.rhalf) begin
              nv  = 1'b1;
              nib = {rx_pins.rxd[1:0], s_q.rlo};
            end
          end else begin
            nv = 1'b1;
          end
        end
        default: s_d.rs = R_IDLE;
      endcase
    end
    if (nv) begin
      s_d.bhalf = ~s_q.bhalf;
      s_d.lonib = nib;
      byt = {nib, s_q.lonib};
      bv  = s_q.bhalf;
    end
    if (bv) begin
      if (s_q.rcnt != 14'h3fff) begin
        s_d.rcnt = s_q.rcnt + 14'h0001;
      end
      case (s_q.rcnt)
        14'd12: s_d.rtype[15:8] = byt;
        14'd13: s_d.rtype[7:0]  = byt;
        14'd14: s_d.rtci[15:8]  = byt;
        14'd15: s_d.rtci[7:0]   = byt;
        default: ;
      endcase
    end

    // Transmit
    if (tedge) begin
      if (!s_q.rmii) begin
        s_d.tx.txd = tx_src.nib;
        s_d.tx.en  = tx_src.valid & s_q.ncr[NCR_TE];
        s_d.tx.er  = tx_src.er & s_d.tx.en;
        s_d.take   = s_d.tx.en;
      end else if (s_q.tphase) begin
        s_d.tx.txd = {2'b00, s_q.thi};
        s_d.tphase = 1'b0;
        s_d.take   = 1'b1;
      end else begin
        s_d.tx.en  = tx_src.valid & s_q.ncr[NCR_TE];
        s_d.tx.txd = {2'b00, tx_src.nib[1:0]};
        s_d.tx.er  = 1'b0;
        s_d.thi    = tx_src.nib[3:2];
        s_d.tphase = s_d.tx.en;
      end
    end

    // Descriptor rings; a fault in the same cycle beats the clear
    if (wr && paddr == OFF_TBQP) begin
      s_d.terr = 1'b0;
    end
    if (rx_desc_next) begin
      s_d.rcur = rx_desc_w0[RXW_WRAP] ? s_q.rbase
                 : s_q.rcur + DESC_STEP;
    end
    if (tx_desc_next) begin
      s_d.tcur = tx_desc_w1[TXW_WRAP] ? s_q.tbase
                 : s_q.tcur + DESC_STEP;
      s_d.tbufs = tx_desc_w1[TXW_LAST] ? 8'h00
                  : s_q.tbufs + 8'h01;
      // Zero length or a 128th buffer without the last flag marks the frame bad
      if (tx_desc_w1[10:0] == 11'h000
          || (s_q.tbufs >= 8'(TX_BUFS - 1)
              && !tx_desc_w1[TXW_LAST])) begin
        s_d.terr = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q       <= '0;
      s_q.ncfg  <= NCFG_RST;
      s_q.tid   <= 16'h0000;
      s_q.ms    <= M_IDLE;
      s_q.rs    <= R_IDLE;
      s_q.midle <= 1'b1;
      s_q.mdo   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata          = s_q.rdata;
  assign pready          = psel & penable;
  assign pslverr         = psel & penable & ~hit;
  assign mdc             = s_q.mdc;
  assign mdio_o          = s_q.mdo;
  assign mdio_oe         = s_q.moe;
  assign mgmt_done_pulse = s_q.mirq;
  assign tx_pins         = s_q.tx;
  assign tx_take         = s_q.take;
  assign rx_stat         = s_q.stat;
  assign rx_desc_ptr     = s_q.rcur;
  // Ownership is read straight from the fetched word
  assign rx_desc_ours    = ~rx_desc_w0[RXW_OWN];
  assign tx_desc_ptr     = s_q.tcur;
  assign tx_desc_ours    = ~tx_desc_w1[TXW_OWN];
  assign tx_desc_err     = s_q.terr;
endmodule
`default_nettype wire

// ---- include/emc_pkg.sv ----
// Constants and carriers for the receive classifier, MDIO and MII block
// Function
// - Flag type match on frame bytes 13-14
// - Type match value resets to zero
// - Type match only reported, never filters
// - Type 0x8100 sets VLAN status bit 21
// - Null VID sets bit 20 too
// - Copy priority and CFI into status
// - Config bit 8 raises length limit
// - Management write starts shift, flags completion
// - MSB out, MDIO in, each MDC
// - Live shift contents; bits end home
// - Divide-by-32 setting gives about 2000 cycles
// - Select bit picks reduced or full interface
// - Reduced mode pairs dibits into nibbles
// - Reduced mode ignores collision and tx error
// - Receive ownership is word 0 bit 0
// - Receive wrap bit returns to ring base
// - Transmit buffers 1-2047 bytes, 128 per frame
// - Transmit ownership bit 31, wrap bit 30
package emc_pkg;
  localparam logic [7:0] OFF_NCR   = 8'h00;
  localparam logic [7:0] OFF_NCFG  = 8'h04;
  localparam logic [7:0] OFF_NSR   = 8'h08;
  localparam logic [7:0] OFF_RBQP  = 8'h18;
  localparam logic [7:0] OFF_TBQP  = 8'h1c;
  localparam logic [7:0] OFF_MAN   = 8'h34;
  localparam logic [7:0] OFF_TID   = 8'hb8;
  localparam logic [7:0] OFF_USRIO = 8'hc0;
  localparam logic [31:0] NCFG_RST = 32'h0000_0800;
  localparam int NCR_RE    = 2;
  localparam int NCR_TE    = 3;
  localparam int CFG_BIG   = 8;
  localparam int CFG_CLK   = 10;
  localparam int NSR_MDIO  = 1;
  localparam int NSR_IDLE  = 2;
  localparam int ST_TID    = 22;
  localparam int ST_VLAN   = 21;
  localparam int ST_PRI    = 20;
  localparam int ST_PRIO   = 17;
  localparam int ST_CFI    = 16;
  localparam int RXW_OWN   = 0;
  localparam int RXW_WRAP  = 1;
  localparam int TXW_OWN   = 31;
  localparam int TXW_WRAP  = 30;
  localparam int TXW_LAST  = 15;
  localparam logic [15:0] TPID_VLAN = 16'h8100;
  localparam int MAX_STD   = 1518;
  localparam int MAX_BIG   = 1536;
  localparam int TX_BUFS   = 128;
  localparam logic [31:0] DESC_STEP = 32'h0000_0008;
  localparam logic [5:0] MDIO_PRE  = 6'h1f;
  localparam logic [5:0] MDIO_LAST = 6'h1f;
  localparam logic [5:0] MDIO_TA   = 6'h0e;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [6:0] MDC_BASE  = 7'h08;
  localparam logic [3:0] SFD_NIB   = 4'hd;
  localparam logic [1:0] SFD_DIBIT = 2'h3;

  typedef struct packed {
    logic       clk;
    logic [3:0] rxd;
    logic       dv;
    logic       crs;
    logic       er;
    logic       col;
  } emc_rx_pins_t;

  typedef struct packed {
    logic [3:0] txd;
    logic       en;
    logic       er;
  } emc_tx_pins_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] nib;
    logic       er;
  } emc_tx_src_t;

  typedef struct packed {
    logic        valid;
    logic        too_long;
    logic [31:0] word;
  } emc_rx_stat_t;
endpackage

// ---- tb/emc_mac_chk.sv ----
// Port-level assertions for the MAC core
`timescale 1ns/1ps
`default_nettype none
module emc_mac_chk (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  mdc,
  input wire logic                  mgmt_done_pulse,
  input wire emc_pkg::emc_rx_stat_t rx_stat,
  input wire logic [31:0]           rx_desc_w0,
  input wire logic                  rx_desc_next,
  input wire logic [31:0]           rx_desc_ptr,
  input wire logic                  rx_desc_ours,
  input wire logic [31:0]           tx_desc_w1,
  input wire logic                  tx_desc_next,
  input wire logic [31:0]           tx_desc_ptr,
  input wire logic                  tx_desc_ours
);
  import emc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Checks
  // ----
  chk_rx_owner_bit: assert property (
    rx_desc_ours == !rx_desc_w0[RXW_OWN]) else $error("rx owner wrong");
  chk_tx_owner_bit: assert property (
    tx_desc_ours == !tx_desc_w1[TXW_OWN]) else $error("tx owner wrong");
  chk_rx_ring_step: assert property (
    rx_desc_next && !rx_desc_w0[RXW_WRAP] |=>
    rx_desc_ptr == $past(rx_desc_ptr) + DESC_STEP) else $error("rx step");
  chk_tx_ring_step: assert property (
    tx_desc_next && !tx_desc_w1[TXW_WRAP] |=>
    tx_desc_ptr == $past(tx_desc_ptr) + DESC_STEP) else $error("tx step");
  chk_prio_tag_vlan: assert property (
    rx_stat.valid && rx_stat.word[ST_PRI] |-> rx_stat.word[ST_VLAN])
    else $error("priority tag without vlan");
  chk_done_one_cycle: assert property (
    mgmt_done_pulse |=> !mgmt_done_pulse) else $error("done too long");
  chk_mdc_high_half: assert property (
    $rose(mdc) |-> mdc [*4]) else $error("mdc high half short");
  chk_stat_one_cycle: assert property (
    rx_stat.valid |=> !rx_stat.valid) else $error("status too long");
endmodule
`default_nettype wire

// ---- tb/emc_phy_model.sv ----
// PHY model: reference clock, MII/RMII receive source, MDIO responder
`timescale 1ns/1ps
`default_nettype none
module emc_phy_model #(
  parameter logic [15:0] RD_DATA = 16'h0
) (
  input  wire logic             pclk,
  input  wire logic             mdc,
  input  wire logic             mdio_o,
  input  wire logic             mdio_oe,
  output logic                  mdio_i,
  output logic                  tx_or_ref_clock,
  output emc_pkg::emc_rx_pins_t rx_pins,
  output logic [13:0]           got
);
  import emc_pkg::*;
  logic       rck, dv, crs, col, act, rm_q, p_oe, p_o;
  logic [2:0] mq;
  logic [3:0] rxd;
  int         cnt, r;
  initial begin
    {rck, dv, crs, col, act, rm_q, p_oe, p_o, mq, rxd, got} = '0;
    cnt = 0;
    r = 0;
  end
  // ----
  // Clock and pins
  // ----
  // 50 MHz from five system clocks; runs free as a reference clock does
  always @(posedge pclk) begin
    cnt <= (cnt == 4) ? 0 : cnt + 1;
    rck <= (cnt < 2);
  end
  assign tx_or_ref_clock = rck;
  assign rx_pins = '{clk: act && !rm_q && rck, rxd: rxd, dv: dv, crs: crs,
                     er: 1'h0, col: col};
  // Released MDIO floats to the pull-up level
  assign mdio_i = mdio_oe ? mdio_o : (p_oe ? p_o : 1'h1);
  // Bit before each MDC rise is taken; TA then data driven after falls
  always @(posedge pclk) begin
    mq <= {mdc, mdio_o, mdio_oe};
    if (mdio_oe && !mq[0]) begin
      r <= 0;
    end else if (mdc && !mq[2]) begin
      if (r >= 32 && r < 46) begin
        got <= {got[12:0], mq[1]};
      end
      r <= r + 1;
    end
    if (!mdc && mq[2]) begin
      p_oe <= (r >= 47 && r <= 63);
      p_o <= (r == 47) ? 1'h0 : RD_DATA[(63 - r) & 15];
    end
  end
  task automatic sym(input logic [3:0] d, input logic rm);
    @(negedge rck);
    rxd <= d;
    dv <= 1'h1;
    crs <= !rm;
    col <= rm;
  endtask
  task automatic send(input logic rm, input logic [15:0] typ, tci,
                      input int len);
    logic [7:0] b;
    logic [3:0] n;
    int         j;
    rm_q <= rm;
    act <= 1'h1;
    for (int k = 0; k < 16 + 2 * len; k++) begin
      j = (k - 16) >>> 1;
      b = j == 12 ? typ[15:8] : j == 13 ? typ[7:0] :
          j == 14 ? tci[15:8] : j == 15 ? tci[7:0] : j[7:0];
      n = k < 15 ? 4'h5 : k == 15 ? 4'hd : (k[0] ? b[7:4] : b[3:0]);
      if (rm) begin
        sym({2'h0, n[1:0]}, rm);
        sym({2'h0, n[3:2]}, rm);
      end else begin
        sym(n, rm);
      end
    end
    @(negedge rck);
    dv <= 1'h0;
    crs <= 1'h0;
    col <= 1'h0;
    rxd <= ~rxd;
    repeat (4) @(negedge rck);
    act <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_eth_mac_rx_classify_mdio_init.sv ----
// Self-checking bench for the MAC core
`timescale 1ns/1ps
`default_nettype none
module test_eth_mac_rx_classify_mdio_init;
  import emc_pkg::*;
  localparam logic [31:0] MAN_RD = 32'h608a_0000;
  localparam logic [15:0] RD_DATA = 16'hbeef;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic         mdc, mdio_i, mdio_o, mdio_oe, mgmt_done_pulse, tx_take;
  logic         tx_or_ref_clock, rx_desc_next, tx_desc_next;
  logic         rx_desc_ours, tx_desc_ours, tx_desc_err;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rx_desc_w0, rx_desc_ptr, r;
  logic [31:0]  tx_desc_w1, tx_desc_ptr;
  logic [13:0]  got;
  emc_rx_pins_t rx_pins;
  emc_tx_pins_t tx_pins;
  emc_tx_src_t  tx_src;
  emc_rx_stat_t rx_stat, st;
  int           n_errors, compares, cyc, n_st;
  emc_mac_core DUT (.*);
  emc_phy_model #(.RD_DATA(RD_DATA)) phy (.pclk(pclk), .mdc(mdc),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdio_i(mdio_i),
    .tx_or_ref_clock(tx_or_ref_clock), .rx_pins(rx_pins), .got(got));
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // ----
  // Shared tasks
  // ----
  task automatic bad(input logic [31:0] g, e);
    n_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) bad(g, e);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (rx_stat.valid === 1'h1) begin
      st <= rx_stat;
      n_st <= n_st + 1;
    end
    if (cyc == 80000) begin
      n_errors++;
      give_verdict;
    end
  end
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    apb(1'h0, OFF_NCFG, 32'h0);
    chk(r, NCFG_RST);
    apb(1'h0, OFF_TID, 32'h0);
    chk(r, 32'h0);
    apb(1'h0, OFF_NSR, 32'h0);
    chk(r & 32'h4, 32'h4);
    apb(1'h0, 8'h0c, 32'h0);
    chk({31'h0, perr}, 32'h1);
    chk(r, 32'h0);
  endtask
  task automatic step(input logic [31:0] w0, w1);
    rx_desc_w0 <= w0;
    tx_desc_w1 <= w1;
    rx_desc_next <= 1'h1;
    tx_desc_next <= 1'h1;
    @(posedge pclk);
    rx_desc_next <= 1'h0;
    tx_desc_next <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic t_ring;
    apb(1'h1, OFF_RBQP, 32'h100);
    apb(1'h1, OFF_TBQP, 32'h200);
    step(32'h0, 32'h0);
    chk(rx_desc_ptr, 32'h108);
    chk(tx_desc_ptr, 32'h208);
    chk({29'h0, tx_desc_err, rx_desc_ours, tx_desc_ours}, 32'h7);
    step(32'h3, 32'hc000_0000);
    chk(rx_desc_ptr, 32'h100);
    chk(tx_desc_ptr, 32'h200);
    chk({29'h0, tx_desc_err, rx_desc_ours, tx_desc_ours}, 32'h4);
    apb(1'h1, OFF_TBQP, 32'h200);
    step(32'h0, 32'h0000_8010);
    chk({31'h0, tx_desc_err}, 32'h0);
    chk(tx_desc_ptr, 32'h208);
  endtask
  task automatic rxf(input logic rm, big, input logic [15:0] tid, typ, tci,
                     input int len);
    logic v;
    int   n0;
    v = (typ === TPID_VLAN);
    apb(1'h1, OFF_NCR, 32'h0);
    apb(1'h1, OFF_NCFG, {20'h0, 2'h2, 1'h0, big, 8'h0});
    apb(1'h1, OFF_USRIO, {31'h0, rm});
    apb(1'h1, OFF_TID, {16'h0, tid});
    apb(1'h1, OFF_RBQP, 32'h100);
    apb(1'h1, OFF_NCR, 32'h4);
    n0 = n_st;
    phy.send(rm, typ, tci, len);
    for (int t = 0; t < 100 && n_st == n0; t++) @(posedge pclk);
    chk({31'h0, n_st != n0}, 32'h1);
    chk({29'h0, st.word[22:20]}, {29'h0, typ === tid, v,
        v && tci[11:0] === 12'h0});
    if (v) chk({28'h0, st.word[19:16]}, {28'h0, tci[15:12]});
    chk({31'h0, st.too_long},
        {31'h0, len > (big ? MAX_BIG : MAX_STD)});
  endtask
  task automatic t_tx(input logic rm, input logic [5:0] exp);
    apb(1'h1, OFF_NCR, 32'h0);
    apb(1'h1, OFF_USRIO, {31'h0, rm});
    apb(1'h1, OFF_NCR, 32'h8);
    tx_src <= '{valid: 1'h1, nib: 4'ha, er: 1'h1};
    for (int t = 0; t < 100 && tx_take !== 1'h1; t++) @(posedge pclk);
    chk({26'h0, tx_pins}, {26'h0, exp});
    tx_src <= '0;
    @(posedge pclk);
  endtask
  task automatic t_mdio;
    int t0;
    apb(1'h1, OFF_NCR, 32'h0);
    apb(1'h1, OFF_NCFG, NCFG_RST);
    apb(1'h1, OFF_MAN, MAN_RD);
    t0 = cyc;
    apb(1'h0, OFF_NSR, 32'h0);
    chk(r & 32'h4, 32'h0);
    repeat (1500) @(posedge pclk);
    apb(1'h0, OFF_MAN, 32'h0);
    compares++;
    if (r === MAN_RD) bad(r, MAN_RD);
    while (mgmt_done_pulse !== 1'h1 && cyc - t0 < 3000) @(posedge pclk);
    compares++;
    if (cyc - t0 < 1900 || cyc - t0 > 2200) bad(cyc - t0, 32'h800);
    apb(1'h0, OFF_NSR, 32'h0);
    chk(r & 32'h4, 32'h4);
    apb(1'h0, OFF_MAN, 32'h0);
    chk(r, {MAN_RD[31:16], RD_DATA});
    chk({18'h0, got}, {18'h0, MAN_RD[31:18]});
  endtask
  initial begin
    {presetn, psel, penable, pwrite, rx_desc_next, tx_desc_next} = '0;
    {paddr, pwdata, rx_desc_w0, tx_desc_w1, tx_src} = '0;
    {n_errors, compares, cyc, n_st} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset;
    t_ring;
    rxf(1'h0, 1'h0, 16'h8100, 16'h8100, 16'hb000, 64);
    rxf(1'h0, 1'h0, 16'h8100, 16'h8100, 16'h4123, 1519);
    rxf(1'h0, 1'h1, 16'h8100, 16'h0800, 16'h0000, 1519);
    rxf(1'h1, 1'h0, 16'h4321, 16'h4321, 16'h0000, 64);
    t_tx(1'h0, 6'h2b);
    t_tx(1'h1, 6'h0a);
    t_mdio;
    give_verdict;
  end
endmodule
bind emc_mac_core emc_mac_chk u_chk (.*);
`default_nettype wire
